// >>> verilog/spc_core.sv
// Speed pulse calibration core: slope tracking, thresholds, offset and direction
`include "spc_core_defines.svh"

// Functional notes
// - First output pulse fires on the first recognised rising slope after power-up.
// - Second pulse fires immediately on the next rising edge.
// - Uncalibrated pulses trigger on the noise detection threshold, not hysteresis.
// - Noise detection threshold starts at twice the minimum amplitude limit.
// - Uncalibrated threshold tracks amplitude, floored at twice the limit.
// - Offset updates need two valid extrema and matching edge orientation.
// - Positive offset steps only during a rising edge.
// - Offset updating is independent of output pulse generation.
// - Successful offset correction enters calibrated mode using adaptive hysteresis.
// - Calibrated threshold is half the amplitude, floored at twice the limit.
// - Peak detection and offset calculation drive the offset DAC word.
// - Hysteresis comparator compares speed samples against hysteresis once calibrated, against the noise threshold before.
// - Direction and vibration derived from direction samples, carried with pulses.
// - Reset and start-up both return the core to uncalibrated mode.
// - First two pulses always emitted; later ones calibrated with direction.
// - First pulse after power-on carries no direction.
// - Hysteresis is one eighth of amplitude, never below the limit.
// - Direction-based vibration suppression only after calibration.
module spc_core (
   input  wire logic                            mclk_in,
   input  wire logic                            reset_in,
   input  wire spc_pkg::spc_sample_s            speed_in,
   input  wire spc_pkg::spc_sample_s            dir_in,
   output      spc_pkg::spc_pulse_s             pulse_out,
   output      logic signed [`SPC_SAMPLE_W-1:0] offset_dac_out,
   output      logic                            calibrated_out,
   output      logic [`SPC_AMP_W-1:0]           noise_detect_threshold_out,
   output      logic [`SPC_AMP_W-1:0]           hysteresis_out
);
   import spc_pkg::*;

   // ==========================================================
   // Floors, all from the one amplitude limit
   localparam logic [`SPC_AMP_W-1:0] HYST_FLOOR  = `SPC_MIN_AMP_LIMIT;
   localparam logic [`SPC_AMP_W-1:0] NOISE_FLOOR = `SPC_AMP_W'(`SPC_MIN_AMP_LIMIT * 2);

   spc_state_s state_reg;
   spc_state_s state_next;

   // Sign extension to 14 bits so threshold sums cannot wrap
   function automatic logic signed [13:0] sx(input logic signed [`SPC_SAMPLE_W-1:0] v);
      sx = $signed({{2{v[`SPC_SAMPLE_W-1]}}, v});
   endfunction : sx

   logic signed [13:0]          x;
   logic [`SPC_AMP_W-1:0]       thr;
   logic                        rise_hit;
   logic                        fall_hit;
   logic                        new_ext;
   logic                        xing;
   logic signed [13:0]          diff;
   logic [`SPC_AMP_W-1:0]       amp;
   logic signed [12:0]          mid;
   logic                        step_up;
   logic                        step_dn;
   logic                        step_any;

   // ==========================================================
   // Next-state logic
   always_comb begin
      state_next          = state_reg;
      state_next.pulse.strobe = 1'b0;
      x        = sx(speed_in.data);
      thr      = state_reg.calibrated ? state_reg.hyst : state_reg.noise_thr;
      rise_hit = x > sx(state_reg.run_lo) + $signed({1'b0, thr});
      fall_hit = x < sx(state_reg.run_hi) - $signed({1'b0, thr});
      new_ext  = 1'b0;
      xing     = 1'b0;
      diff     = '0;
      amp      = '0;
      mid      = '0;
      step_up  = 1'b0;
      step_dn  = 1'b0;
      step_any = 1'b0;
      // Latest direction polarity, held until the next speed crossing
      if (dir_in.valid) begin
         state_next.dir_hold = ~dir_in.data[`SPC_SAMPLE_W-1];
         state_next.dir_seen = 1'b1;
      end
      if (speed_in.valid) begin
         // Running peak trackers
         if (x > sx(state_reg.run_hi)) begin
            state_next.run_hi = speed_in.data;
         end
         if (x < sx(state_reg.run_lo)) begin
            state_next.run_lo = speed_in.data;
         end
         // Rising zero crossing samples the direction probe
         state_next.prev_neg = speed_in.data[`SPC_SAMPLE_W-1];
         xing = state_reg.prev_neg && !speed_in.data[`SPC_SAMPLE_W-1];
         if (xing && state_reg.dir_seen) begin
            state_next.vib      = state_reg.dir_ok && (state_reg.dir_hold != state_reg.dir_last);
            state_next.dir_last = state_reg.dir_hold;
            state_next.dir_ok   = 1'b1;
         end
         // Offset step, gated only by extrema and slope, never by the pulse path
         if (state_reg.off_due && state_reg.ext_cnt == `SPC_EXT_NEEDED) begin
            mid     = 13'($signed({state_reg.ext_hi[`SPC_SAMPLE_W-1], state_reg.ext_hi})
                          + $signed({state_reg.ext_lo[`SPC_SAMPLE_W-1], state_reg.ext_lo})) >>> 1;
            step_up = (mid < 0) && state_reg.edge_st == SPC_EDGE_RISE;
            step_dn = (mid > 0) && state_reg.edge_st == SPC_EDGE_FALL;
            step_any = step_up || step_dn || (mid == 0);
            if (step_any) begin
               state_next.offset     = state_reg.offset - mid[`SPC_SAMPLE_W-1:0];
               state_next.off_due    = 1'b0;
               state_next.calibrated = 1'b1;
            end
         end
         // Slope tracker; pulses only on rising recognition
         unique case (state_reg.edge_st)
            SPC_EDGE_IDLE, SPC_EDGE_FALL: begin
               if (rise_hit) begin
                  state_next.edge_st = SPC_EDGE_RISE;
                  state_next.run_hi  = speed_in.data;
                  if (state_reg.edge_st == SPC_EDGE_FALL) begin
                     state_next.ext_lo = state_reg.run_lo;
                     new_ext = 1'b1;
                  end
                  // Vibration drops a pulse only once calibrated, never the first two
                  if (!(state_reg.calibrated && state_next.vib && state_reg.pulse_cnt >= `SPC_FREE_PULSES)) begin
                     state_next.pulse.strobe    = 1'b1;
                     state_next.pulse.has_dir   = state_reg.calibrated && state_next.dir_ok
                                                  && state_reg.pulse_cnt != 3'h0;
                     state_next.pulse.dir       = state_next.dir_last;
                     state_next.pulse.vibration = state_next.vib;
                     if (state_reg.pulse_cnt != 3'h7) begin
                        state_next.pulse_cnt = state_reg.pulse_cnt + 3'h1;
                     end
                  end
               end else if (fall_hit && state_reg.edge_st == SPC_EDGE_IDLE) begin
                  state_next.edge_st = SPC_EDGE_FALL;   // Start on a falling slope, no pulse
                  state_next.run_lo  = speed_in.data;
               end
            end
            SPC_EDGE_RISE: begin
               if (fall_hit) begin
                  state_next.edge_st = SPC_EDGE_FALL;
                  state_next.ext_hi  = state_reg.run_hi;
                  state_next.run_lo  = speed_in.data;
                  new_ext = 1'b1;
               end
            end
            default: begin
               state_next.edge_st = SPC_EDGE_IDLE;
            end
         endcase
         // Extremum count and amplitude-driven thresholds
         if (new_ext) begin
            if (state_reg.ext_cnt != `SPC_EXT_NEEDED) begin
               state_next.ext_cnt = state_reg.ext_cnt + 2'h1;
            end
            if (state_next.ext_cnt == `SPC_EXT_NEEDED) begin
               diff = sx(state_next.ext_hi) - sx(state_next.ext_lo);
               amp  = diff[13] ? '0 : diff[`SPC_AMP_W-1:0];
               state_next.off_due = 1'b1;
               if (state_reg.calibrated) begin
                  state_next.noise_thr = (amp >> 1) > NOISE_FLOOR ? (amp >> 1) : NOISE_FLOOR;
               end else begin
                  state_next.noise_thr = amp > NOISE_FLOOR ? amp : NOISE_FLOOR;
               end
               state_next.hyst = (amp >> `SPC_HYST_SHIFT) > HYST_FLOOR
                                 ? (amp >> `SPC_HYST_SHIFT) : HYST_FLOOR;
            end
         end
      end
   end

   // ==========================================================
   // State register; reset restarts calibration from scratch
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         state_reg           <= '0;
         state_reg.noise_thr <= NOISE_FLOOR;
         state_reg.hyst      <= HYST_FLOOR;
         state_reg.offset    <= `SPC_OFFSET_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state register
   assign pulse_out                  = state_reg.pulse;
   assign offset_dac_out             = state_reg.offset;
   assign calibrated_out             = state_reg.calibrated;
   assign noise_detect_threshold_out = state_reg.noise_thr;
   assign hysteresis_out             = state_reg.hyst;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   property p_init_thr;
      @(posedge mclk_in) disable iff (1'b0) reset_in |=> state_reg.noise_thr == NOISE_FLOOR && !state_reg.calibrated;
   endproperty
   a_init_thr: assert property (p_init_thr) else $error("threshold or mode wrong after reset");
   property p_uncal_reset;
      @(posedge mclk_in) disable iff (1'b0) reset_in ##1 reset_in |=> !calibrated_out && pulse_out.strobe == 1'b0;
   endproperty
   a_uncal_reset: assert property (p_uncal_reset) else $error("not uncalibrated after reset");
   property p_noise_floor;
      noise_detect_threshold_out >= NOISE_FLOOR;
   endproperty
   a_noise_floor: assert property (p_noise_floor) else $error("noise threshold below floor");
   property p_cal_half;
      (new_ext && state_next.ext_cnt == `SPC_EXT_NEEDED && state_reg.calibrated && (amp >> 1) > NOISE_FLOOR)
         |=> noise_detect_threshold_out == $past(amp) >> 1;
   endproperty
   a_cal_half: assert property (p_cal_half) else $error("calibrated threshold not half amplitude");
   property p_hyst;
      (new_ext && state_next.ext_cnt == `SPC_EXT_NEEDED) |=> hysteresis_out >= HYST_FLOOR
         && (hysteresis_out == HYST_FLOOR || hysteresis_out == ($past(amp) >> `SPC_HYST_SHIFT));
   endproperty
   a_hyst: assert property (p_hyst) else $error("hysteresis not amplitude over eight");
   property p_step_ext;
      (offset_dac_out != $past(offset_dac_out)) |-> $past(state_reg.ext_cnt) == `SPC_EXT_NEEDED;
   endproperty
   a_step_ext: assert property (p_step_ext) else $error("offset moved before two extrema");
   // Watches the DAC word itself, so a mis-gated step shows even if step_up were wrong
   property p_pos_step;
      ($past(speed_in.valid) && offset_dac_out > $past(offset_dac_out)) |-> $past(state_reg.edge_st) == SPC_EDGE_RISE;
   endproperty
   a_pos_step: assert property (p_pos_step) else $error("positive step outside rising edge");
   property p_neg_step;
      step_dn |=> calibrated_out && offset_dac_out < $past(offset_dac_out) && $past(state_reg.edge_st) == SPC_EDGE_FALL;
   endproperty
   a_neg_step: assert property (p_neg_step) else $error("negative step wrong");
   property p_pulse_rise;
      pulse_out.strobe |-> state_reg.edge_st == SPC_EDGE_RISE && $past(state_reg.edge_st) != SPC_EDGE_RISE;
   endproperty
   a_pulse_rise: assert property (p_pulse_rise) else $error("pulse without rising recognition");
   property p_first_nodir;
      (pulse_out.strobe && state_reg.pulse_cnt == 3'h1) |-> !pulse_out.has_dir;
   endproperty
   a_first_nodir: assert property (p_first_nodir) else $error("first pulse carries direction");
   property p_free_pulses;
      (rise_hit && speed_in.valid && state_reg.edge_st != SPC_EDGE_RISE && state_reg.pulse_cnt < `SPC_FREE_PULSES)
         |=> pulse_out.strobe;
   endproperty
   a_free_pulses: assert property (p_free_pulses) else $error("early pulse lost");
   property p_dir_needs_cal;
      (pulse_out.strobe && pulse_out.has_dir) |-> calibrated_out || $past(calibrated_out);
   endproperty
   a_dir_needs_cal: assert property (p_dir_needs_cal) else $error("direction before calibration");

   c_first_pulse: cover property (pulse_out.strobe ##[1:1000] pulse_out.strobe);
   c_calibrate:   cover property ($rose(calibrated_out));
   c_dir_pulse:   cover property (pulse_out.strobe && pulse_out.has_dir);
   c_vib:         cover property (pulse_out.strobe && pulse_out.vibration);

endmodule : spc_core

// >>> pkg/spc_core_defines.svh
// Constants of the speed pulse calibration core
`ifndef SPC_CORE_DEFINES_SVH
`define SPC_CORE_DEFINES_SVH

// ==========================================================
// Widths
`define SPC_SAMPLE_W      12
`define SPC_AMP_W         13

// ==========================================================
// Threshold base and shift, reset values, extremum and free-pulse counts
`define SPC_MIN_AMP_LIMIT 13'h0020
`define SPC_OFFSET_RESET  12'h000
`define SPC_EXT_NEEDED    2'h2
`define SPC_FREE_PULSES   3'h2
`define SPC_HYST_SHIFT    3

`endif

// >>> pkg/spc_pkg.sv
// Types of the speed pulse calibration core
`include "spc_core_defines.svh"

package spc_pkg;

   // ==========================================================
   // Slope tracker states, Gray coded
   typedef enum logic [1:0] {
      SPC_EDGE_IDLE = 2'h0,
      SPC_EDGE_RISE = 2'h1,
      SPC_EDGE_FALL = 2'h3
   } spc_edge_e;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic                              valid;
      logic signed [`SPC_SAMPLE_W-1:0]   data;
   } spc_sample_s;

   typedef struct packed {
      logic strobe;
      logic has_dir;
      logic dir;
      logic vibration;
   } spc_pulse_s;

   // ==========================================================
   // Whole core state
   typedef struct packed {
      spc_edge_e                         edge_st;
      logic signed [`SPC_SAMPLE_W-1:0]   run_hi;
      logic signed [`SPC_SAMPLE_W-1:0]   run_lo;
      logic signed [`SPC_SAMPLE_W-1:0]   ext_hi;
      logic signed [`SPC_SAMPLE_W-1:0]   ext_lo;
      logic [1:0]                        ext_cnt;
      logic [`SPC_AMP_W-1:0]             noise_thr;
      logic [`SPC_AMP_W-1:0]             hyst;
      logic                              calibrated;
      logic signed [`SPC_SAMPLE_W-1:0]   offset;
      logic                              off_due;
      logic [2:0]                        pulse_cnt;
      logic                              dir_seen;
      logic                              dir_hold;
      logic                              dir_ok;
      logic                              dir_last;
      logic                              vib;
      logic                              prev_neg;
      spc_pulse_s                        pulse;
   } spc_state_s;

endpackage : spc_pkg

// >>> dv/spc_tcu_model.sv
// Far-side receiver model: counts output pulses and keeps the last direction
module spc_tcu_model (
   input  wire logic                mclk_in,
   input  wire logic                reset_in,
   input  wire spc_pkg::spc_pulse_s pulse_in,
   output      logic [7:0]          count_out,
   output      logic                dir_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import spc_pkg::*;

   // ==========================================================
   // Pulse receiver
   // Direction only taken from pulses that carry it, a plain speed pulse keeps the old one
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         count_out <= 8'h00;
         dir_out   <= 1'b0;
      end else if (pulse_in.strobe === 1'b1) begin
         count_out <= count_out + 8'h01;
         if (pulse_in.has_dir === 1'b1) begin
            dir_out <= pulse_in.dir;
         end
      end
   end
endmodule : spc_tcu_model

// >>> dv/tb_speed_pulse_calibration_core.sv
// Self-checking bench of the speed pulse calibration core
`include "spc_core_defines.svh"
`define SPC_CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
   $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module tb_speed_pulse_calibration_core;
   timeunit 1ns;
   timeprecision 1ps;
   import spc_pkg::*;

   // ==========================================================
   // Signals
   logic                            mclk_in  = 1'b0;
   logic                            reset_in = 1'b1;
   spc_sample_s                     speed_in = '0;
   spc_sample_s                     dir_in   = '0;
   spc_pulse_s                      pulse_out;
   logic signed [`SPC_SAMPLE_W-1:0] offset_dac_out;
   logic                            calibrated_out;
   logic [`SPC_AMP_W-1:0]           noise_detect_threshold_out;
   logic [`SPC_AMP_W-1:0]           hysteresis_out;
   logic [7:0]                      tcu_count;
   logic                            tcu_dir;
   logic                            dir_neg  = 1'b0;
   spc_pulse_s                      exp_q[$];
   spc_pulse_s                      head_p;
   int                              err_count = 0;
   int                              compares  = 0;
   int                              cycles    = 0;

   // ==========================================================
   // Clock, design and far-side model
   always #12.5 mclk_in = ~mclk_in;

   spc_core dut (
      .mclk_in                    (mclk_in),
      .reset_in                   (reset_in),
      .speed_in                   (speed_in),
      .dir_in                     (dir_in),
      .pulse_out                  (pulse_out),
      .offset_dac_out             (offset_dac_out),
      .calibrated_out             (calibrated_out),
      .noise_detect_threshold_out (noise_detect_threshold_out),
      .hysteresis_out             (hysteresis_out)
   );

   spc_tcu_model tcu (
      .mclk_in   (mclk_in),
      .reset_in  (reset_in),
      .pulse_in  (pulse_out),
      .count_out (tcu_count),
      .dir_out   (tcu_dir)
   );

   // ==========================================================
   // Tasks
   task automatic close_out;
      $display("Counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   // Random idle gaps carry junk data without valid, which must be ignored
   task automatic send(input logic signed [11:0] value);
      int gap;
      int mag;
      gap = $urandom_range(0, 2);
      mag = int'($urandom_range(16, 2047));
      repeat (gap) begin
         @(posedge mclk_in);
         speed_in <= spc_sample_s'{1'b0, 12'($urandom)};
         dir_in   <= spc_sample_s'{1'b0, 12'($urandom)};
      end
      @(posedge mclk_in);
      speed_in <= spc_sample_s'{1'b1, value};
      // Direction sign follows dir_neg so a flip can be provoked
      dir_in   <= spc_sample_s'{1'b1, 12'(dir_neg ? -mag : mag)};
   endtask : send

   task automatic idle(input int n);
      repeat (n) begin
         @(posedge mclk_in);
         speed_in.valid <= 1'b0;
         dir_in.valid   <= 1'b0;
      end
   endtask : idle

   // Steps of 0x10 so every ramp lands exactly on its end value
   task automatic ramp(input int from, input int to);
      int v;
      v = from;
      while (v != to) begin
         v += (to > v) ? 16 : -16;
         send(12'(v));
      end
      idle(4);
   endtask : ramp

   task automatic expect_pulse(input logic has_dir);
      exp_q.push_back(spc_pulse_s'{1'b1, has_dir, has_dir, 1'b0});
   endtask : expect_pulse

   // Levels sampled at the falling edge where they are settled
   task automatic levels(input string name, input logic cal, input logic signed [11:0] off,
                         input logic [12:0] noise, input logic [12:0] hyst);
      @(negedge mclk_in);
      `SPC_CHK(calibrated_out, cal)
      `SPC_CHK(offset_dac_out, off)
      `SPC_CHK(noise_detect_threshold_out, noise)
      `SPC_CHK(hysteresis_out, hyst)
      $display("Test %s done", name);
   endtask : levels

   // ==========================================================
   // Output watcher: every strobe takes the oldest expectation
   always @(posedge mclk_in) begin
      if (pulse_out.strobe === 1'b1) begin
         if (exp_q.size() == 0) begin
            `SPC_CHK(pulse_out, 4'h0)
         end else begin
            head_p = exp_q.pop_front();
            `SPC_CHK(pulse_out, head_p)
         end
      end
   end

   // Hang guard, the whole sequence needs about a thousand cycles
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         close_out();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(31));
      repeat (10) @(posedge mclk_in);
      levels("reset", 1'b0, 12'h000, 13'h0040, 13'h0020);
      @(posedge mclk_in);
      reset_in <= 1'b0;
      // Exactly at the start threshold is not a rise
      send(12'h040);
      idle(3);
      `SPC_CHK(tcu_count, 8'h00)
      expect_pulse(1'b0);
      ramp(16'h0040, 16'h0120);
      `SPC_CHK(tcu_count, 8'h01)
      ramp(16'h0120, -16'h0100);
      `SPC_CHK(tcu_count, 8'h01)
      expect_pulse(1'b0);
      ramp(-16'h0100, 16'h0120);
      `SPC_CHK(tcu_count, 8'h02)
      // Positive residual waits for a falling edge
      levels("uncal_pair", 1'b0, 12'h000, 13'h0220, 13'h0044);
      ramp(16'h0120, -16'h0200);
      levels("cal_entry", 1'b1, -12'sh010, 13'h0220, 13'h0044);
      expect_pulse(1'b1);
      ramp(-16'h0200, 16'h0120);
      `SPC_CHK(tcu_count, 8'h03)
      `SPC_CHK(tcu_dir, 1'b1)
      levels("cal_pair", 1'b1, 12'h060, 13'h0190, 13'h0064);
      // Direction flips: one pulse still passes, its crossing flags vibration, the next rise is dropped
      dir_neg = 1'b1;
      ramp(16'h0120, -16'h0200);
      expect_pulse(1'b1);
      ramp(-16'h0200, 16'h0120);
      `SPC_CHK(tcu_count, 8'h04)
      ramp(16'h0120, -16'h0200);
      ramp(-16'h0200, 16'h0120);
      `SPC_CHK(tcu_count, 8'h04)
      `SPC_CHK(tcu_dir, 1'b1)
      levels("vibration", 1'b1, 12'h140, 13'h0190, 13'h0064);
      dir_neg = 1'b0;
      // Reset in mid-run drops calibration again
      @(posedge mclk_in);
      reset_in <= 1'b1;
      idle(2);
      levels("mid_reset", 1'b0, 12'h000, 13'h0040, 13'h0020);
      @(posedge mclk_in);
      reset_in <= 1'b0;
      expect_pulse(1'b0);
      ramp(16'h0000, 16'h0120);
      `SPC_CHK(tcu_count, 8'h01)
      `SPC_CHK(exp_q.size(), 0)
      levels("restart", 1'b0, 12'h000, 13'h0040, 13'h0020);
      close_out();
   end
endmodule : tb_speed_pulse_calibration_core
